// ==== shared/isa_exec_pkg.sv ====
// constants for the instruction execution unit: register map, command fields, opcodes, states
// assumes a 32-bit axi4-lite master with byte addresses
package isa_exec_pkg;
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] OFF_CMD       = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_ACC       = 8'h08;
    localparam logic [7:0] OFF_TBL_HIGH  = 8'h0c;
    localparam logic [7:0] OFF_PC        = 8'h10;
    localparam logic [7:0] OFF_FILE_ADDR = 8'h14;
    localparam logic [7:0] OFF_FILE_DATA = 8'h18;
    localparam logic [7:0] OFF_STACK     = 8'h1c;
    // command word fields
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_REG_LSB  = 8;
    localparam int CMD_DEST_BIT = 16;
    // status bits
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_ZERO_BIT  = 1;
    localparam int ST_GIE_BIT   = 2;
    localparam int ST_SKIP_BIT  = 3;
    localparam int ST_CYC_LSB   = 4;
    localparam int ST_SP_LSB    = 8;
    // opcodes
    localparam logic [2:0] OP_NOP        = 3'h0;
    localparam logic [2:0] OP_ENABLE_IRQ = 3'h1;
    localparam logic [2:0] OP_DISABLE_IRQ= 3'h2;
    localparam logic [2:0] OP_COMP_JUMP  = 3'h3;
    localparam logic [2:0] OP_INCREMENT_OP       = 3'h4;
    localparam logic [2:0] OP_INCREMENT_OP_SKIP  = 3'h5;
    localparam logic [2:0] OP_SOFT_INT   = 3'h6;
    localparam logic [2:0] OP_OR_REG     = 3'h7;
    // instruction cycle counts
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [10:0] SOFT_INT_VECTOR = 11'h001;
    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_HOLD = 3'b100
    } exec_state_t;
endpackage

// ==== src/isa_exec_unit.sv ====
// instruction execution unit: accumulator, file registers, pc, stack, flags, axi4-lite slave
// assumes one clock per instruction cycle and a single axi4-lite master
// Contract
// - enable-interrupts sets the global interrupt enable to 1 in one cycle.
// - computed jump loads pc[10:8] from table high pointer bits 2..0 and pc[7:0] from the accumulator.
// - computed jump is unconditional, takes two cycles and leaves the flags alone.
// - increment adds one to file register 0..127 and writes the accumulator if dest is 0, else the register.
// - increment takes one cycle, wraps 0xff to 0x00, and sets zero exactly when the result is zero.
// - software interrupt pushes pc plus one onto the stack, then loads 0x001 into the 11-bit pc.
// - software interrupt takes three cycles and leaves the flags alone.
// - increment-skip increments to dest and on a zero result discards the next instruction, taking two cycles.
// - disable-interrupts clears the global interrupt enable to 0 in one cycle.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
module isa_exec_unit
#(
    parameter int FILE_DEPTH  = 128,
    parameter int STACK_DEPTH = 8
) (
    // clock and reset
    input  wire logic                             clk_sys,
    input  wire logic                             rst_n,
    // axi4-lite write
    input  wire logic [isa_exec_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    // axi4-lite read
    input  wire logic [isa_exec_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    // core state
    output logic                                  global_irq_enable
);
    import isa_exec_pkg::*;
    localparam int SP_W = $clog2(STACK_DEPTH);
    exec_state_t       state_reg;
    logic [7:0]        accumulator;
    logic [7:0]        table_high_pointer;
    logic [10:0]       pc_reg;
    logic              zero_reg;
    logic              skip_reg;
    logic [1:0]        cyc_reg;
    logic [1:0]        remain_reg;
    logic [16:0]       cmd_reg;
    logic [6:0]        file_addr_reg;
    logic [7:0]        file_mem [FILE_DEPTH];
    logic [10:0]       stack_mem [STACK_DEPTH];
    logic [SP_W-1:0]   sp_reg;
    logic [AXI_ADDR_W-1:0] aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              aw_full_reg;
    logic              w_full_reg;
    logic [2:0]  op;
    logic [6:0]  op_reg_addr;
    logic        op_dest;
    logic [7:0]  file_val;
    logic [7:0]  increment_op_sum;
    logic [7:0]  or_val;
    logic [7:0]  alu_res;
    logic        writes_dest;
    logic        do_write;
    logic        idle;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        wr_hit;
    assign op          = cmd_reg[CMD_OP_LSB +: 3];
    assign op_reg_addr = cmd_reg[CMD_REG_LSB +: 7];
    assign op_dest     = cmd_reg[CMD_DEST_BIT];
    assign file_val    = file_mem[op_reg_addr];
    assign increment_op_sum    = file_val + 8'h01;
    assign or_val      = accumulator | file_val;
    assign alu_res     = (op == OP_OR_REG) ? or_val : increment_op_sum;
    assign writes_dest = (state_reg == ST_EXEC) &&
                         (op == OP_INCREMENT_OP || op == OP_INCREMENT_OP_SKIP || op == OP_OR_REG);
    assign idle        = (state_reg == ST_IDLE);
    assign do_write    = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_hit      = aw_addr_reg inside {OFF_CMD, OFF_STATUS, OFF_ACC, OFF_TBL_HIGH, OFF_PC,
                                             OFF_FILE_ADDR, OFF_FILE_DATA, OFF_STACK};
    // byte-lane merge of the held write data over a zero base
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_word[8*b +: 8] = w_strb_reg[b] ? w_data_reg[8*b +: 8] : 8'h00;
        end
    end
    // instruction sequencing; commands arriving while busy are dropped
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg  <= ST_IDLE;
            cmd_reg    <= '0;
            remain_reg <= 2'h0;
            cyc_reg    <= 2'h0;
            skip_reg   <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: if (do_write && aw_addr_reg == OFF_CMD) begin
                    cmd_reg   <= wr_word[16:0];
                    state_reg <= ST_EXEC;
                end
                ST_EXEC: begin
                    skip_reg  <= 1'b0;
                    cyc_reg   <= CYC_ONE;
                    state_reg <= ST_IDLE;
                    case (op)
                        OP_COMP_JUMP: begin
                            cyc_reg    <= CYC_TWO;
                            remain_reg <= CYC_ONE;
                            state_reg  <= ST_HOLD;
                        end
                        OP_SOFT_INT: begin
                            cyc_reg    <= CYC_THREE;
                            remain_reg <= CYC_TWO;
                            state_reg  <= ST_HOLD;
                        end
                        OP_INCREMENT_OP_SKIP: begin
                            if (increment_op_sum == 8'h00) begin
                                skip_reg   <= 1'b1;
                                cyc_reg    <= CYC_TWO;
                                remain_reg <= CYC_ONE;
                                state_reg  <= ST_HOLD;
                            end
                        end
                        default: ;
                    endcase
                end
                ST_HOLD: begin
                    // extra cycles stand for pipeline refill or the injected nop
                    remain_reg <= remain_reg - 2'h1;
                    if (remain_reg == CYC_ONE) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    // accumulator, flags, pointer registers, pc
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            accumulator        <= RESET_BYTE;
            table_high_pointer <= RESET_BYTE;
            pc_reg             <= '0;
            zero_reg           <= 1'b0;
            global_irq_enable  <= 1'b0;
            file_addr_reg      <= '0;
        end else if (state_reg == ST_EXEC) begin
            accumulator <= (writes_dest && !op_dest) ? alu_res : accumulator;
            zero_reg <= (op == OP_INCREMENT_OP || op == OP_OR_REG) ? (alu_res == 8'h00) : zero_reg;
            case (op)
                OP_ENABLE_IRQ:  global_irq_enable <= 1'b1;
                OP_DISABLE_IRQ: global_irq_enable <= 1'b0;
                OP_COMP_JUMP:   pc_reg <= {table_high_pointer[2:0], accumulator};
                OP_SOFT_INT:    pc_reg <= SOFT_INT_VECTOR;
                OP_INCREMENT_OP_SKIP:   pc_reg <= pc_reg + ((increment_op_sum == 8'h00) ? 11'h002 : 11'h001);
                default:        pc_reg <= pc_reg + 11'h001;
            endcase
        end else if (idle && do_write) begin
            case (aw_addr_reg)
                OFF_ACC:       accumulator        <= wr_word[7:0];
                OFF_TBL_HIGH:  table_high_pointer <= wr_word[7:0];
                OFF_PC:        pc_reg             <= wr_word[10:0];
                OFF_FILE_ADDR: file_addr_reg      <= wr_word[6:0];
                default: ;
            endcase
        end
    end
    // file registers and the return stack
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sp_reg <= '0;
        end else if (writes_dest && op_dest) begin
            file_mem[op_reg_addr] <= alu_res;
        end else if (state_reg == ST_EXEC && op == OP_SOFT_INT) begin
            stack_mem[sp_reg] <= pc_reg + 11'h001;
            sp_reg            <= sp_reg + 1'b1;
        end else if (idle && do_write && aw_addr_reg == OFF_FILE_DATA) begin
            file_mem[file_addr_reg] <= wr_word[7:0];
        end
    end
    // axi write channels: address and data are held independently
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr_reg   <= '0;
            w_data_reg    <= '0;
            w_strb_reg    <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg   <= s_axi_awaddr;
                aw_full_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                w_full_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            OFF_CMD:       rd_word[16:0] = cmd_reg;
            OFF_STATUS: begin
                rd_word[ST_BUSY_BIT]        = !idle;
                rd_word[ST_ZERO_BIT]        = zero_reg;
                rd_word[ST_GIE_BIT]         = global_irq_enable;
                rd_word[ST_SKIP_BIT]        = skip_reg;
                rd_word[ST_CYC_LSB +: 2]    = cyc_reg;
                rd_word[ST_SP_LSB +: SP_W]  = sp_reg;
            end
            OFF_ACC:       rd_word[7:0]  = accumulator;
            OFF_TBL_HIGH:  rd_word[7:0]  = table_high_pointer;
            OFF_PC:        rd_word[10:0] = pc_reg;
            OFF_FILE_ADDR: rd_word[6:0]  = file_addr_reg;
            OFF_FILE_DATA: rd_word[7:0]  = file_mem[file_addr_reg];
            OFF_STACK:     rd_word[10:0] = stack_mem[sp_reg - 1'b1];
            default:       rd_hit = 1'b0;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_gie_set_eni: assert property (state_reg == ST_EXEC && op == OP_ENABLE_IRQ |=> global_irq_enable)
        else $error("gie not set after enable");
    a_gie_clr_disable_interrupts_op: assert property (state_reg == ST_EXEC && op == OP_DISABLE_IRQ |=> !global_irq_enable)
        else $error("gie not cleared after disable");
    a_jump_target: assert property (state_reg == ST_EXEC && op == OP_COMP_JUMP |=>
        pc_reg == {$past(table_high_pointer[2:0]), $past(accumulator)}) else $error("computed jump target wrong");
    a_jump_two_cycles: assert property (state_reg == ST_EXEC && op == OP_COMP_JUMP |=>
        state_reg == ST_HOLD && $stable(zero_reg) ##1 state_reg == ST_IDLE) else $error("jump length or flags wrong");
    a_increment_op_zero_flag: assert property (state_reg == ST_EXEC && op == OP_INCREMENT_OP |=>
        zero_reg == ($past(increment_op_sum) == 8'h00) && state_reg == ST_IDLE) else $error("increment zero flag wrong");
    a_increment_op_to_acc: assert property (state_reg == ST_EXEC && op == OP_INCREMENT_OP && !op_dest |=>
        accumulator == $past(file_val) + 8'h01) else $error("increment result not in accumulator");
    a_int_push_vector: assert property (state_reg == ST_EXEC && op == OP_SOFT_INT |=>
        pc_reg == SOFT_INT_VECTOR && stack_mem[sp_reg - 1'b1] == $past(pc_reg) + 11'h001)
        else $error("soft interrupt push or vector wrong");
    a_int_three_cycles: assert property (state_reg == ST_EXEC && op == OP_SOFT_INT |=>
        (state_reg == ST_HOLD && $stable(zero_reg)) [*2] ##1 state_reg == ST_IDLE) else $error("trap length wrong");
    a_skip_two_cycles: assert property (state_reg == ST_EXEC && op == OP_INCREMENT_OP_SKIP && increment_op_sum == 8'h00
        |=> skip_reg && state_reg == ST_HOLD && pc_reg == $past(pc_reg) + 11'h002 ##1 state_reg == ST_IDLE)
        else $error("skip length or pc wrong");
    a_skip_zero_keep: assert property (state_reg == ST_EXEC && op == OP_INCREMENT_OP_SKIP |=> $stable(zero_reg))
        else $error("increment-skip changed zero flag");
    a_or_result: assert property (state_reg == ST_EXEC && op == OP_OR_REG && !op_dest |=>
        accumulator == $past(or_val) && zero_reg == ($past(or_val) == 8'h00)) else $error("or result or zero wrong");
    c_skip_taken: cover property (state_reg == ST_EXEC && op == OP_INCREMENT_OP_SKIP && increment_op_sum == 8'h00);
    c_soft_int:   cover property (state_reg == ST_EXEC && op == OP_SOFT_INT);
    c_jump:       cover property (state_reg == ST_EXEC && op == OP_COMP_JUMP);
endmodule

// ==== bench/mcu_isa_branch_increment_op_or_ops_test.sv ====
// self-checking bench for the instruction execution unit, driven over its axi4-lite slave
// assumes isa_exec_pkg and isa_exec_unit are compiled first; one 200 MHz clock, no partner model
module mcu_isa_branch_increment_op_or_ops_test;
    timeunit 1ns;
    timeprecision 1ps;
    import isa_exec_pkg::*;

    logic        clk_sys, rst_n;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, global_irq_enable;
    logic [31:0] s_axi_wdata, s_axi_rdata, st, v, pc0;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          errors, samples_checked;

    isa_exec_unit isa_exec_unit_i (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .global_irq_enable(global_irq_enable));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic hang(input logic [31:0] what);
        errors++;
        $display("ERROR t=%0t got=%h exp=%h (wait ran out)", $time, what, 32'h0);
        test_done();
    endtask

    // handshakes are judged at the negedge before the edge that takes them; ready is registered
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hit, w_hit, b_hit, done;
        int n;
        done = 1'b0;
        n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done && n < 50) begin
            @(negedge clk_sys);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            b_hit = (s_axi_bvalid === 1'b1);
            if (b_hit) r = s_axi_bresp;
            @(posedge clk_sys);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
            if (b_hit) s_axi_bready <= 1'b0;
            done = b_hit;
            n++;
        end
        if (!done) hang({24'h0, a});
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        int n;
        done = 1'b0;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done && n < 50) begin
            @(negedge clk_sys);
            done = (s_axi_rvalid === 1'b1);
            if (done) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
            end
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
            n++;
        end
        if (!done) hang({24'h0, a});
    endtask

    // poll busy; a stuck instruction counts as a hang
    task automatic run_op(input logic [2:0] op, input logic [6:0] fa, input logic d);
        int n;
        axi_write(OFF_CMD, {15'h0, d, 1'b0, fa, 5'h0, op}, rs);
        n = 0;
        st = 32'h1;
        while (st[ST_BUSY_BIT] !== 1'b0 && n < 20) begin
            axi_read(OFF_STATUS, st, rs);
            n++;
        end
        if (st[ST_BUSY_BIT] !== 1'b0) hang(st);
    endtask

    task automatic set_file(input logic [6:0] a, input logic [7:0] d);
        axi_write(OFF_FILE_ADDR, {25'h0, a}, rs);
        axi_write(OFF_FILE_DATA, {24'h0, d}, rs);
    endtask

    task automatic get_file(input logic [6:0] a, output logic [31:0] d);
        axi_write(OFF_FILE_ADDR, {25'h0, a}, rs);
        axi_read(OFF_FILE_DATA, d, rs);
    endtask

    task automatic t_irq();
        run_op(OP_ENABLE_IRQ, 7'h0, 1'b0);
        check({31'h0, global_irq_enable}, 32'h1);
        check({30'h0, st[ST_CYC_LSB+:2]}, 32'h1);
        run_op(OP_DISABLE_IRQ, 7'h0, 1'b0);
        check({31'h0, global_irq_enable}, 32'h0);
        check({31'h0, st[ST_GIE_BIT]}, 32'h0);
        // a plain nop only steps the pc and leaves the enable alone
        axi_read(OFF_PC, pc0, rs);
        run_op(OP_NOP, 7'h0, 1'b0);
        axi_read(OFF_PC, v, rs);
        check(v, {21'h0, pc0[10:0] + 11'h1});
        check({31'h0, global_irq_enable}, 32'h0);
        $display("t_irq done");
    endtask

    task automatic t_increment_op();
        set_file(7'h7f, 8'hff);
        run_op(OP_INCREMENT_OP, 7'h7f, 1'b1);
        get_file(7'h7f, v);
        check(v, 32'h0);
        check({30'h0, st[ST_ZERO_BIT], st[ST_SKIP_BIT]}, 32'h2);
        check({30'h0, st[ST_CYC_LSB+:2]}, 32'h1);
        run_op(OP_INCREMENT_OP, 7'h7f, 1'b0);
        axi_read(OFF_ACC, v, rs);
        check(v, 32'h1);
        check({31'h0, st[ST_ZERO_BIT]}, 32'h0);
        get_file(7'h7f, v);
        check(v, 32'h0);
        $display("t_increment_op done");
    endtask

    // zero is clear on entry, so an update by the skip op would show
    task automatic t_skip();
        set_file(7'h03, 8'hff);
        axi_read(OFF_PC, pc0, rs);
        run_op(OP_INCREMENT_OP_SKIP, 7'h03, 1'b1);
        get_file(7'h03, v);
        check(v, 32'h0);
        check({30'h0, st[ST_ZERO_BIT], st[ST_SKIP_BIT]}, 32'h1);
        check({30'h0, st[ST_CYC_LSB+:2]}, 32'h2);
        axi_read(OFF_PC, v, rs);
        check(v, {21'h0, pc0[10:0] + 11'h2});
        run_op(OP_INCREMENT_OP_SKIP, 7'h03, 1'b0);
        axi_read(OFF_ACC, v, rs);
        check(v, 32'h1);
        check({29'h0, st[ST_SKIP_BIT], st[ST_CYC_LSB+:2]}, 32'h1);
        $display("t_skip done");
    endtask

    task automatic t_or();
        axi_write(OFF_ACC, 32'haa, rs);
        set_file(7'h0a, 8'h50);
        run_op(OP_OR_REG, 7'h0a, 1'b1);
        get_file(7'h0a, v);
        check(v, 32'hfa);
        axi_read(OFF_ACC, v, rs);
        check(v, 32'haa);
        check({29'h0, st[ST_ZERO_BIT], st[ST_CYC_LSB+:2]}, 32'h1);
        axi_write(OFF_ACC, 32'h0, rs);
        set_file(7'h0b, 8'h00);
        run_op(OP_OR_REG, 7'h0b, 1'b0);
        check({31'h0, st[ST_ZERO_BIT]}, 32'h1);
        $display("t_or done");
    endtask

    // zero is set on entry; branches must leave it set
    task automatic t_branch();
        axi_write(OFF_ACC, 32'h34, rs);
        axi_write(OFF_TBL_HIGH, 32'hfa, rs);
        run_op(OP_COMP_JUMP, 7'h0, 1'b0);
        axi_read(OFF_PC, v, rs);
        check(v, 32'h234);
        check({29'h0, st[ST_ZERO_BIT], st[ST_CYC_LSB+:2]}, 32'h6);
        axi_write(OFF_PC, 32'h0a0, rs);
        axi_read(OFF_STATUS, pc0, rs);
        run_op(OP_SOFT_INT, 7'h0, 1'b0);
        axi_read(OFF_PC, v, rs);
        check(v, {21'h0, SOFT_INT_VECTOR});
        axi_read(OFF_STACK, v, rs);
        check(v & 32'h7ff, 32'h0a1);
        check({29'h0, st[ST_ZERO_BIT], st[ST_CYC_LSB+:2]}, 32'h7);
        check({29'h0, st[ST_SP_LSB+:3]}, {29'h0, pc0[ST_SP_LSB+:3] + 3'h1});
        $display("t_branch done");
    endtask

    task automatic t_unmapped();
        axi_write(8'h40, 32'h5a, rs);
        check({30'h0, rs}, {30'h0, RESP_SLVERR});
        axi_read(8'h40, v, rs);
        check({30'h0, rs}, {30'h0, RESP_SLVERR});
        check(v, 32'h0);
        $display("t_unmapped done");
    endtask

    initial begin
        errors = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        s_axi_awaddr = 8'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        axi_read(OFF_STATUS, v, rs);
        check(v, 32'h0);
        check({31'h0, global_irq_enable}, 32'h0);
        t_irq();
        t_increment_op();
        t_skip();
        t_or();
        t_branch();
        t_unmapped();
        test_done();
    end
endmodule
